/* rtl/acs_sequencer.sv */
/*
  channel sequencer for a 14-bit successive-approximation converter:
  wishbone register file, channel selection, ordering, oversampling,
  averaging and result storage.
  assumes the converter presents its raw result on conv_data_i by the end
  of the hold interval, on the same clock.
*/
// How it works
// - cells convert from the highest selected cell down to the lowest.
// - every conversion holds for a fixed 3.44 us, whatever the period.
// - the converter delivers 14-bit raw successive-approximation results.
// - acquisition time before each hold comes from a programmable period.
// - mux reaches 16 cells, stack, temps, references, rails and 8 external inputs.
// - single sampling or two averaging modes, chosen by the oversample code and the cycled select bit.
// - each channel is included or skipped by its mask bit; cells also by the cell count.
// - cells, external inputs and internal channels have separate periods.
// - cell count sets cells in use; unused ones drop from 16 downward.
// - cells above the count have their comparators switched off.
// - between sequences the mux parks on the channel of the cell count.
// - oversample count is 2, 4, 8, 16 or 32.
// - averaging yields the mean as one 16-bit result with two extra bits; CH_DTEMP keeps its first sample.
// - only the averaged value is readable, never the raw samples.
// - order is cells, then external inputs, then internal channels.
// - cycled mode samples each channel once per pass, repeating passes.
// - non-cycled mode takes all samples of a channel back to back.
// - the first sample of a channel uses its own period.
// - a command register write starts the sequence.
// - oversample periods follow the single period or the fast/external fields.
`timescale 1ns/10ps
module acs_sequencer #(
  parameter int HOLD_CYCLES = acs_pkg::HOLD_CYC,
  parameter int TICK_CYCLES = acs_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // converter and multiplexer
  output acs_pkg::acs_conv_s      conv_o,
  input  wire logic [13:0]        conv_data_i,
  // status and protection
  output logic                    busy_o,
  output logic      [15:0]        comp_en_o
);

  localparam int A_HOLD = HOLD_CYCLES;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]                cell_mask_r;
  logic [13:0]                other_mask_r;
  logic [4:0]                 cell_count_r;
  logic [23:0]                avg_cfg_r;
  logic [23:0]                period_r;
  logic                       done_r;
  acs_pkg::acs_state_e        state_r;
  logic [4:0]                 pos_r;
  logic [4:0]                 samp_r;
  logic [4:0]                 pass_r;
  logic [4:0]                 prev_r;
  logic                       cap_v_r;
  logic [acs_pkg::ACC_W-1:0]  acc_r [acs_pkg::NUM_CHAN];
  logic [acs_pkg::RES_W-1:0]  res_r [acs_pkg::NUM_CHAN];
  logic                       tmr_conv_start;
  logic                       tmr_done;
  logic                       nxt_found;
  logic [4:0]                 nxt_pos;
  logic [31:0]                rd_data;
  logic [15:0]                cell_used;

  // position in the sequence to multiplexer code: cells run downward
  function automatic logic [4:0] pos2chan(input logic [4:0] p);
    pos2chan = (p < 5'h10) ? 5'h0F - p : p;
  endfunction : pos2chan

  // byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmerge = (old & ~m) | (dat & m);
  endfunction : wmerge

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr_en     = wb_req && wb_we_i;
  wire        cmd_start = wr_en && (wb_adr_i == acs_pkg::ADDR_CMD) && wb_sel_i[0]
                          && wb_dat_i[acs_pkg::CMD_START_BIT];
  wire [31:0] avg_wr    = wmerge({8'h00, avg_cfg_r}, wb_dat_i, wb_sel_i);
  wire [31:0] mask_wr   = wmerge({16'h0000, cell_mask_r}, wb_dat_i, wb_sel_i);
  wire [31:0] omask_wr  = wmerge({18'h00000, other_mask_r}, wb_dat_i, wb_sel_i);
  wire [31:0] per_wr    = wmerge({8'h00, period_r}, wb_dat_i, wb_sel_i);
  wire [2:0]  code_wr   = avg_wr[acs_pkg::AVG_CODE_LSB +: 3];
  wire [2:0]  code_cl   = ({2'b00, code_wr} > acs_pkg::CODE_MAX) ? acs_pkg::CODE_MAX[2:0] : code_wr;
  wire [4:0]  res_idx   = 5'((wb_adr_i - acs_pkg::ADDR_RESULT0) >> 2);

  // ----------------------------------------------------------------
  // channel enables
  // ----------------------------------------------------------------
  // cells at or above the count drop out from the top
  for (genvar i = 0; i < acs_pkg::NUM_CELLS; i++) begin : g_cell
    assign cell_used[i] = (5'(i) < cell_count_r);
  end

  wire [29:0] chan_en = {other_mask_r, cell_mask_r & cell_used};
  wire [4:0]  idle_ch = (cell_count_r == 5'h00) ? 5'h00 :
                        (cell_count_r > 5'h10) ? 5'h0F : cell_count_r - 5'h01;

  // ----------------------------------------------------------------
  // averaging configuration
  // ----------------------------------------------------------------
  wire       cycled   = avg_cfg_r[acs_pkg::AVG_CYCLE_BIT];
  wire [2:0] code     = avg_cfg_r[acs_pkg::AVG_CODE_LSB +: 3];
  wire [4:0] last_idx = 5'((32'h1 << code) - 32'h1);
  wire [7:0] per_cell = period_r[acs_pkg::PER_CELL_LSB +: 8];
  wire [7:0] per_aux  = period_r[acs_pkg::PER_AUX_LSB +: 8];
  wire [7:0] per_int  = period_r[acs_pkg::PER_INT_LSB +: 8];
  wire [7:0] per_fast = avg_cfg_r[acs_pkg::AVG_FAST_LSB +: 8];
  wire [7:0] per_ext  = avg_cfg_r[acs_pkg::AVG_EXT_LSB +: 8];

  // lowest enabled position at or after the current one
  always_comb begin
    nxt_found = 1'b0;
    nxt_pos   = 5'h00;
    for (int p = acs_pkg::NUM_CHAN - 1; p >= 0; p--) begin
      if (5'(p) >= pos_r && chan_en[pos2chan(5'(p))]) begin
        nxt_found = 1'b1;
        nxt_pos   = 5'(p);
      end
    end
  end

  // ----------------------------------------------------------------
  // sample selection and period
  // ----------------------------------------------------------------
  wire       in_find   = (state_r == acs_pkg::ST_FIND);
  wire [4:0] cur_ch    = pos2chan(pos_r);
  wire [4:0] tgt_ch    = in_find ? pos2chan(nxt_pos) : cur_ch;
  wire       tgt_first = in_find ? (!cycled || pass_r == 5'h00) : 1'b0;
  wire       use_own   = tgt_first || cycled;
  wire [7:0] tgt_per   = (tgt_ch < acs_pkg::CH_AUX0)  ? (use_own ? per_cell : per_fast) :
                         (tgt_ch < acs_pkg::CH_STACK) ? (use_own ? per_aux : per_ext) :
                         tgt_first ? per_int :
                         (tgt_ch == acs_pkg::CH_CORE18) ? per_ext : per_fast;
  wire       first_cur = cycled ? (pass_r == 5'h00) : (samp_r == 5'h00);
  wire       last_samp = cycled ? (pass_r == last_idx) : (samp_r == last_idx);
  wire       in_acq    = (state_r == acs_pkg::ST_ACQ);
  wire       tmr_start = (in_find && nxt_found) || (in_acq && cap_v_r && !cycled && !last_samp);

  // ----------------------------------------------------------------
  // accumulation and scaling
  // ----------------------------------------------------------------
  wire                      is_dtemp = (cur_ch == acs_pkg::CH_DTEMP);
  wire [acs_pkg::ACC_W-1:0] raw_ext  = {5'h00, conv_data_i};
  wire [acs_pkg::ACC_W-1:0] acc_sum  = first_cur ? raw_ext : acc_r[cur_ch] + raw_ext;
  wire [acs_pkg::ACC_W-1:0] acc_nxt  = (is_dtemp && !first_cur) ? acc_r[cur_ch] : acc_sum;
  wire [20:0]               acc_x4   = {acc_nxt, 2'b00};
  wire [15:0]               res_nxt  = is_dtemp ? {acc_nxt[13:0], 2'b00} : 16'(acc_x4 >> code);

  acs_sample_timer #(
    .HOLD_CYCLES (HOLD_CYCLES),
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .start_i      (tmr_start),
    .period_i     (tgt_per),
    .conv_start_o (tmr_conv_start),
    .done_o       (tmr_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= acs_pkg::ST_IDLE;
      busy_o  <= 1'b0;
      done_r  <= 1'b0;
      pos_r   <= 5'h00;
      samp_r  <= 5'h00;
      pass_r  <= 5'h00;
    end else begin
      case (state_r)
        acs_pkg::ST_IDLE: begin
          if (cmd_start) begin
            busy_o  <= 1'b1;
            done_r  <= 1'b0;
            pos_r   <= 5'h00;
            samp_r  <= 5'h00;
            pass_r  <= 5'h00;
            state_r <= acs_pkg::ST_FIND;
          end
        end
        acs_pkg::ST_FIND: begin
          if (nxt_found) begin
            pos_r   <= nxt_pos;
            samp_r  <= 5'h00;
            state_r <= acs_pkg::ST_ACQ;
          end else if (cycled && pass_r != last_idx) begin
            pass_r  <= pass_r + 5'h01;
            pos_r   <= 5'h00;
          end else begin
            busy_o  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= acs_pkg::ST_IDLE;
          end
        end
        acs_pkg::ST_ACQ: begin
          if (cap_v_r) begin
            if (!cycled && !last_samp) begin
              samp_r <= samp_r + 5'h01;
            end else begin
              pos_r   <= pos_r + 5'h01;
              state_r <= acs_pkg::ST_FIND;
            end
          end
        end
        default: state_r <= acs_pkg::ST_IDLE;
      endcase
    end
  end

  // sums per channel, only the finished mean is kept readable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < acs_pkg::NUM_CHAN; i++) begin
        acc_r[i] <= '0;
        res_r[i] <= '0;
      end
    end else if (in_acq && cap_v_r) begin
      acc_r[cur_ch] <= acc_nxt;
      if (last_samp) begin
        res_r[cur_ch] <= res_nxt;
      end
    end
  end

  // converter request, parking channel and comparator enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_o    <= '0;
      cap_v_r   <= 1'b0;
      comp_en_o <= 16'h0000;
      prev_r    <= 5'h1F;
    end else begin
      conv_o.start <= tmr_conv_start;
      cap_v_r      <= tmr_done;
      comp_en_o    <= cell_used;
      if (in_find && nxt_found) begin
        conv_o.chan <= tgt_ch;
      end else if (!busy_o) begin
        conv_o.chan <= idle_ch;
      end
      if (state_r == acs_pkg::ST_IDLE || (in_find && !nxt_found)) begin
        prev_r <= 5'h1F;
      end else if (conv_o.start) begin
        prev_r <= conv_o.chan;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_mask_r  <= acs_pkg::CELL_MASK_RST;
      other_mask_r <= acs_pkg::OTHER_MASK_RST;
      cell_count_r <= acs_pkg::CELL_COUNT_RST;
      avg_cfg_r    <= acs_pkg::AVG_CFG_RST;
      period_r     <= acs_pkg::PERIOD_RST;
    end else if (wr_en) begin
      if (wb_adr_i == acs_pkg::ADDR_CELL_MASK) begin
        cell_mask_r <= mask_wr[15:0];
      end else if (wb_adr_i == acs_pkg::ADDR_OTHER_MASK) begin
        other_mask_r <= omask_wr[13:0];
      end else if (wb_adr_i == acs_pkg::ADDR_CELL_COUNT && wb_sel_i[0]) begin
        cell_count_r <= wb_dat_i[4:0];
      end else if (wb_adr_i == acs_pkg::ADDR_AVG_CFG) begin
        avg_cfg_r <= {avg_wr[23:4], code_cl, avg_wr[0]};
      end else if (wb_adr_i == acs_pkg::ADDR_PERIOD) begin
        period_r <= per_wr[23:0];
      end
    end
  end

  // read selection
  always_comb begin
    if (wb_adr_i == acs_pkg::ADDR_CELL_MASK) begin
      rd_data = {16'h0000, cell_mask_r};
    end else if (wb_adr_i == acs_pkg::ADDR_OTHER_MASK) begin
      rd_data = {18'h00000, other_mask_r};
    end else if (wb_adr_i == acs_pkg::ADDR_CELL_COUNT) begin
      rd_data = {27'h0000000, cell_count_r};
    end else if (wb_adr_i == acs_pkg::ADDR_AVG_CFG) begin
      rd_data = {8'h00, avg_cfg_r};
    end else if (wb_adr_i == acs_pkg::ADDR_PERIOD) begin
      rd_data = {8'h00, period_r};
    end else if (wb_adr_i == acs_pkg::ADDR_STATUS) begin
      rd_data = {19'h00000, conv_o.chan, 6'h00, done_r, busy_o};
    end else if (wb_adr_i == acs_pkg::ADDR_COMP_EN) begin
      rd_data = {16'h0000, comp_en_o};
    end else if (wb_adr_i >= acs_pkg::ADDR_RESULT0 && wb_adr_i < acs_pkg::ADDR_RESULT_END) begin
      rd_data = {16'h0000, res_r[res_idx]};
    end else begin
      rd_data = 32'h00000000;
    end
  end

  // one-cycle acknowledge with registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hold_fixed_span: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_o.start |-> ##A_HOLD cap_v_r)
    else $error("hold interval length wrong");

  a_chan_order_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_o.start && prev_r != 5'h1F |->
      ((prev_r < 5'h10) ? (conv_o.chan <= prev_r || conv_o.chan >= 5'h10) : (conv_o.chan >= prev_r)))
    else $error("channel order broken");

  a_chan_only_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_o.start |-> chan_en[conv_o.chan])
    else $error("disabled channel converted");

  a_idle_park_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy_o && $past(!busy_o) && !$past(rst_i) && $stable(cell_count_r) |-> conv_o.chan == idle_ch)
    else $error("mux not parked on idle channel");

  a_start_sets_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_start && !busy_o |=> busy_o && state_r == acs_pkg::ST_FIND)
    else $error("start write did not start sequence");

  a_comp_mask_count: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(cell_count_r) && !$past(rst_i) && cell_count_r != 5'h00 && cell_count_r <= 5'h10 |->
      comp_en_o[4'(cell_count_r - 5'h01)] && ((comp_en_o >> cell_count_r) == 16'h0000))
    else $error("comparator enables disagree with cell count");

  a_noncyc_repeat_same: assert property (@(posedge clk_i) disable iff (rst_i)
    in_acq && cap_v_r && !cycled && !last_samp |=> $stable(pos_r) && state_r == acs_pkg::ST_ACQ)
    else $error("non-cycled mode left channel early");

  a_cycled_next_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    in_find && !nxt_found && cycled && pass_r != last_idx |=>
      pass_r == $past(pass_r) + 5'h01 && pos_r == 5'h00 && busy_o)
    else $error("cycled pass not repeated");

endmodule : acs_sequencer

/* include/acs_pkg.sv */
/*
  shared constants and types of the converter channel sequencer:
  register offsets, field positions, reset values, timing counts,
  channel numbering, sequencer states and the converter request bundle.
  assumes a 20 MHz system clock and a 32-bit classic wishbone bus.
*/
package acs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOLD_TIME_NS  = 3440;
  localparam int HOLD_CYC      = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_TIME_NS  = 1000;
  localparam int TICK_CYC      = TICK_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // channel numbering (multiplexer code)
  // ----------------------------------------------------------------
  localparam int         NUM_CELLS = 16;
  localparam int         NUM_CHAN  = 30;
  localparam int         RAW_W     = 14;
  localparam int         RES_W     = 16;
  localparam int         ACC_W     = 19;
  localparam logic [4:0] CH_AUX0   = 5'h10;
  localparam logic [4:0] CH_STACK  = 5'h18;
  localparam logic [4:0] CH_ATEMP  = 5'h19;
  localparam logic [4:0] CH_SREF   = 5'h1A;
  localparam logic [4:0] CH_NEG    = 5'h1B;
  localparam logic [4:0] CH_CORE18 = 5'h1C;
  localparam logic [4:0] CH_DTEMP  = 5'h1D;
  localparam logic [4:0] CODE_MAX  = 5'h05;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD        = 8'h00;
  localparam logic [7:0] ADDR_CELL_MASK  = 8'h04;
  localparam logic [7:0] ADDR_OTHER_MASK = 8'h08;
  localparam logic [7:0] ADDR_CELL_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_AVG_CFG    = 8'h10;
  localparam logic [7:0] ADDR_PERIOD     = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_COMP_EN    = 8'h1C;
  localparam logic [7:0] ADDR_RESULT0    = 8'h40;
  localparam logic [7:0] ADDR_RESULT_END = 8'hB8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT = 0;
  localparam int AVG_CYCLE_BIT = 0;
  localparam int AVG_CODE_LSB  = 1;
  localparam int AVG_FAST_LSB  = 8;
  localparam int AVG_EXT_LSB   = 16;
  localparam int PER_CELL_LSB  = 0;
  localparam int PER_AUX_LSB   = 8;
  localparam int PER_INT_LSB   = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CHAN_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CELL_MASK_RST  = 16'hFFFF;
  localparam logic [13:0] OTHER_MASK_RST = 14'h0000;
  localparam logic [4:0]  CELL_COUNT_RST = 5'h10;
  localparam logic [23:0] AVG_CFG_RST    = 24'h0C0C00;
  localparam logic [23:0] PERIOD_RST     = 24'h1E0C3C;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FIND, ST_ACQ} acs_state_e;

  typedef struct packed {
    logic       start;
    logic [4:0] chan;
  } acs_conv_s;

endpackage : acs_pkg

/* rtl/acs_sample_timer.sv */
/*
  acquisition and hold timer for one conversion: waits the programmed
  acquisition time in microsecond ticks, then starts the converter and
  counts the fixed hold interval.
  assumes start_i comes only while the timer is idle.
*/
`timescale 1ns/10ps
module acs_sample_timer #(
  parameter int HOLD_CYCLES = acs_pkg::HOLD_CYC,
  parameter int TICK_CYCLES = acs_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request
  input  wire logic       start_i,
  input  wire logic [7:0] period_i,
  // events
  output logic            conv_start_o,
  output logic            done_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255 || TICK_CYCLES < 1 || TICK_CYCLES > 255) begin : g_chk
    $error("acs_sample_timer: counts must lie in 1..255");
  end

  logic [7:0] tick_cnt_r;
  logic [7:0] per_cnt_r;
  logic [7:0] hold_cnt_r;
  logic       acq_r;
  logic       hold_r;

  // one-cycle microsecond enable from the restartable divider
  wire tick     = acq_r && (tick_cnt_r == 8'(TICK_CYCLES - 1));
  wire hold_end = hold_r && (hold_cnt_r == 8'(HOLD_CYCLES - 1));

  // acquisition then fixed hold, whatever the period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r   <= 8'h00;
      per_cnt_r    <= 8'h00;
      hold_cnt_r   <= 8'h00;
      acq_r        <= 1'b0;
      hold_r       <= 1'b0;
      conv_start_o <= 1'b0;
      done_o       <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      done_o       <= 1'b0;
      if (start_i) begin
        tick_cnt_r <= 8'h00;
        per_cnt_r  <= period_i;
        hold_cnt_r <= 8'h00;
        acq_r      <= (period_i != 8'h00);
        hold_r     <= (period_i == 8'h00);
        conv_start_o <= (period_i == 8'h00);
      end else if (acq_r) begin
        tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
        if (tick) begin
          per_cnt_r <= per_cnt_r - 8'h01;
          if (per_cnt_r == 8'h01) begin
            acq_r        <= 1'b0;
            hold_r       <= 1'b1;
            conv_start_o <= 1'b1;
          end
        end
      end else if (hold_r) begin
        hold_cnt_r <= hold_cnt_r + 8'h01;
        if (hold_end) begin
          hold_r <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule : acs_sample_timer

/* tb/acs_conv_model.sv */
/*
  converter model: answers each hold with a raw value built from the channel.
  assumes one-cycle start pulses from the sequencer on the same clock.
*/
`timescale 1ns/10ps
module acs_conv_model #(
  parameter int HOLD = 3
) (
  input  wire logic               clk_i,
  input  wire acs_pkg::acs_conv_s conv_i,
  output logic [13:0]             data_o
);
  int cnt = 0;
  // raw result stands only through the hold, inverted pattern otherwise
  always @(posedge clk_i) begin
    if (conv_i.start) cnt <= HOLD + 1;
    else if (cnt > 0) cnt <= cnt - 1;
    data_o <= (cnt > 0 || conv_i.start) ? {conv_i.chan, 9'h0A5} : ~{conv_i.chan, 9'h0A5};
  end
endmodule : acs_conv_model

/* tb/acs_sequencer_tb.sv */
/*
  self-checking bench of the channel sequencer: random masks and counts, four fixed modes.
  assumes acs_pkg compiled first and the converter model beside it.
*/
`timescale 1ns/10ps
module acs_sequencer_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, busy_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] comp_en_o, lf = 16'hD67A, msk;
  logic [13:0] conv_data_i, oth;
  logic [16:0] ce;
  logic [4:0] cnt, seen[$], exp_q[$], ch[$];
  logic [2:0] code;
  acs_pkg::acs_conv_s conv_o;
  int err_count = 0, tests_run = 0, cyc = 0, n;
  acs_sequencer #(.HOLD_CYCLES(3), .TICK_CYCLES(2)) acs_sequencer_inst (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_o, .conv_data_i,
    .busy_o, .comp_en_o);
  acs_conv_model #(.HOLD(3)) acs_conv_model_inst (.clk_i(clk_i), .conv_i(conv_o), .data_o(conv_data_i));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial forever #25 clk_i = ~clk_i;
  // record conversion order, cut a hang short
  always @(posedge clk_i) begin
    if (conv_o.start === 1'b1) seen.push_back(conv_o.chan);
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, acs_pkg::ADDR_CELL_MASK, 0); chk(rd, 32'h0000FFFF);
    wb(0, acs_pkg::ADDR_CELL_COUNT, 0); chk(rd, 32'h00000010);
    wb(0, 8'h3C, 0); chk(rd, 32'h0);
    wb(0, acs_pkg::ADDR_COMP_EN, 0); chk(rd, 32'h0000FFFF);
    wb(1, acs_pkg::ADDR_AVG_CFG, 32'h0000000E);
    wb(0, acs_pkg::ADDR_AVG_CFG, 0); chk(rd, 32'h0000000A);
    wb(1, acs_pkg::ADDR_PERIOD, 32'h00010101);
    wb(0, acs_pkg::ADDR_PERIOD, 0); chk(rd, 32'h00010101);
    for (int m = 0; m < 4; m++) begin
      lf = nxt(lf); msk = lf; lf = nxt(lf); oth = lf[13:0]; lf = nxt(lf);
      cnt = (m == 0) ? 5'h10 : 5'(lf[4:0] % 17);
      code = (m == 3) ? 3'h5 : 3'(m);
      wb(1, acs_pkg::ADDR_CELL_MASK, {16'h0, msk});
      wb(1, acs_pkg::ADDR_CELL_COUNT, {27'h0, cnt});
      wb(1, acs_pkg::ADDR_OTHER_MASK, {18'h0, oth});
      wb(1, acs_pkg::ADDR_AVG_CFG, {16'h0101, 4'h0, code, m == 2});
      ch.delete(); exp_q.delete(); seen.delete();
      for (int i = 15; i >= 0; i--) if (msk[i] && i < cnt) ch.push_back(5'(i));
      for (int i = 0; i < 14; i++) if (oth[i]) ch.push_back(5'(16 + i));
      n = 1 << code;
      for (int p = 0; p < n * ch.size(); p++) exp_q.push_back((m == 2) ? ch[p % ch.size()] : ch[p / n]);
      wb(1, acs_pkg::ADDR_CMD, 32'h1); chk(busy_o, 1);
      while (busy_o !== 1'b0) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      chk(conv_o.chan, (cnt == 0) ? 0 : cnt - 1);
      chk(seen.size(), exp_q.size());
      foreach (exp_q[j]) chk(seen[j], exp_q[j]);
      ce = (17'h1 << cnt) - 17'h1;
      chk(comp_en_o, ce[15:0]);
      wb(0, acs_pkg::ADDR_STATUS, 0); chk(rd, {19'h0, 5'((cnt == 0) ? 0 : cnt - 1), 8'h02});
      foreach (ch[j]) begin
        wb(0, 8'h40 + {ch[j], 2'b00}, 0); chk(rd, {16'h0, ch[j], 9'h0A5, 2'b00});
      end
    end
    summarize();
  end
endmodule : acs_sequencer_tb
